// File: common/pcsr_pkg.sv
// package for the pwm, protection and scratch register block
package pcsr_pkg;

  // -------------------------------------------------------------------------
  // register map (printed offsets are not word multiples: index, byte = 4x)
  // -------------------------------------------------------------------------
  localparam logic [6:0]  PCSR_IDX_RATE    = 7'h1c;
  localparam logic [6:0]  PCSR_IDX_PROT    = 7'h1d;
  localparam logic [6:0]  PCSR_IDX_SCR_LO  = 7'h1e;
  localparam logic [6:0]  PCSR_IDX_SCR_HI  = 7'h1f;
  localparam logic [6:0]  PCSR_IDX_DUTY    = 7'h20;
  localparam logic [6:0]  PCSR_IDX_CTRL    = 7'h21;
  localparam logic [6:0]  PCSR_IDX_STAT    = 7'h22;

  // -------------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------------
  localparam int          PCSR_RATE_LSB    = 0;
  localparam int          PCSR_THERM_BIT   = 2;
  localparam int          PCSR_ILIM_LSB    = 0;
  localparam int          PCSR_CTRL_LOCK   = 0;
  localparam int          PCSR_CTRL_SOFT   = 1;
  localparam logic [7:0]  PCSR_RATE_RST    = 8'h00;
  localparam logic [7:0]  PCSR_PROT_RST    = 8'h01;
  localparam logic [7:0]  PCSR_SCR_RST     = 8'h00;
  localparam logic [7:0]  PCSR_DUTY_RST    = 8'h00;
  localparam logic [7:0]  PCSR_DUTY_FULL   = 8'hff;

  // -------------------------------------------------------------------------
  // timing: clock, pwm rates, 255 steps per period
  // -------------------------------------------------------------------------
  localparam longint      PCSR_CLK_HZ      = 200_000_000;
  localparam longint      PCSR_STEPS       = 255;
  localparam longint      PCSR_F0_HZ       = 100;
  localparam longint      PCSR_F1_HZ       = 200;
  localparam longint      PCSR_F2_HZ       = 325;
  localparam longint      PCSR_F3_HZ       = 400;
  localparam logic [15:0] PCSR_DIV0 =
    16'(PCSR_CLK_HZ / (PCSR_F0_HZ * PCSR_STEPS));
  localparam logic [15:0] PCSR_DIV1 =
    16'(PCSR_CLK_HZ / (PCSR_F1_HZ * PCSR_STEPS));
  localparam logic [15:0] PCSR_DIV2 =
    16'(PCSR_CLK_HZ / (PCSR_F2_HZ * PCSR_STEPS));
  localparam logic [15:0] PCSR_DIV3 =
    16'(PCSR_CLK_HZ / (PCSR_F3_HZ * PCSR_STEPS));

  // chip operating modes seen by the block
  typedef enum logic [1:0] {
    PCSR_MODE_NORMAL   = 2'b00,
    PCSR_MODE_STOP     = 2'b01,
    PCSR_MODE_RESTART  = 2'b10,
    PCSR_MODE_FAILSAFE = 2'b11
  } pcsr_mode_t;

  // decoded protection settings
  typedef struct packed {
    logic       thermal_trip_level;
    logic [1:0] regulator_current_limit_trim;
  } pcsr_prot_t;

endpackage

// File: design/pcsr_top.sv
// pwm rate, protection tuning and host scratch registers with pwm engine
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - full duty keeps switch on, zero duty keeps it off, no toggling.
// - new duty value is applied only at the end of a period.
// - rate field 00/01/10/11 selects 100/200/325/400 Hz.
// - new rate is applied only at the end of a period.
// - rate register bits 7:2 read zero and ignore writes.
// - bit 2 selects default or higher trip level for both thermal levels.
// - current trim 00 -25%, 01 default, 10 +20%, 11 +50%.
// - protection loads 0x01 at power-on; soft reset keeps it when locked.
// - 16-bit scratch in low and high bytes, zero at power-up.
// - scratch survives soft reset, restart and fail-safe modes.
// - scratch writable only in normal mode, readable in stop mode.
// - internal logic never changes the scratch bytes.
// - on-time per period equals duty over 255 of the period.
// - lock takes effect when chip select rises after lock write; holds.
module pcsr_top (
  input  wire logic                core_clk_in,
  input  wire logic                reset_n_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [11:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  input  wire logic [3:0]          pstrb_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire logic                chip_select_n_in,
  input  wire pcsr_pkg::pcsr_mode_t chip_mode_in,
  output logic                     pwm_switch_on_out,
  output logic                     pwm_period_start_out,
  output pcsr_pkg::pcsr_prot_t     prot_setting_out
);
  import pcsr_pkg::*;

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  logic        cs_meta_reg;
  logic        cs_sync_reg;
  logic        cs_prev_reg;
  logic        wr_en;
  logic [6:0]  wr_idx;
  logic        rd_ok;
  logic [1:0]  rate_reg;
  logic [2:0]  prot_reg;
  logic [7:0]  scr_lo_reg;
  logic [7:0]  scr_hi_reg;
  logic [7:0]  duty_reg;
  logic        lock_pend_reg;
  logic        lock_reg;
  logic [1:0]  act_rate_reg;
  logic [7:0]  act_duty_reg;
  logic [15:0] div_cnt_reg;
  logic [7:0]  step_reg;
  logic        step_en;
  logic        period_end;
  logic        soft_rst;
  logic [15:0] div_limit;
  logic [31:0] rd_data;
  logic        wr_rate;
  logic        wr_prot;
  logic        wr_scr_lo;
  logic        wr_scr_hi;
  logic        wr_duty;
  logic        wr_ctrl;
  logic        scr_wr_ok;
  logic        cs_rise;
  logic        sw_on_next;

  // index decode of an aligned word address
  function automatic logic [6:0] word_idx(input logic [11:0] a);
    word_idx = a[8:2];
  endfunction

  // write strobe for one register index
  function automatic logic reg_hit(input logic       en,
                                   input logic [6:0] idx,
                                   input logic [6:0] sel);
    reg_hit = en && (idx == sel);
  endfunction

  // divider period for a rate code
  function automatic logic [15:0] rate_div(input logic [1:0] r);
    unique case (r)
      2'b00: rate_div = PCSR_DIV0;
      2'b01: rate_div = PCSR_DIV1;
      2'b10: rate_div = PCSR_DIV2;
      2'b11: rate_div = PCSR_DIV3;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped or misaligned
  // -------------------------------------------------------------------------
  assign wr_idx  = word_idx(paddr_in);
  assign rd_ok   = (paddr_in[1:0] == 2'b00) && (paddr_in[11:9] == 3'b000) &&
                   (wr_idx >= PCSR_IDX_RATE) && (wr_idx <= PCSR_IDX_STAT);
  assign wr_en   = psel_in && penable_in && pwrite_in && rd_ok &&
                   pstrb_in[0];
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !rd_ok;
  // soft reset request from control word
  assign soft_rst = wr_ctrl && pwdata_in[PCSR_CTRL_SOFT];

  // -------------------------------------------------------------------------
  // per-register write strobes
  // -------------------------------------------------------------------------
  assign wr_rate   = reg_hit(wr_en, wr_idx, PCSR_IDX_RATE);
  assign wr_prot   = reg_hit(wr_en, wr_idx, PCSR_IDX_PROT);
  assign wr_scr_lo = reg_hit(wr_en, wr_idx, PCSR_IDX_SCR_LO);
  assign wr_scr_hi = reg_hit(wr_en, wr_idx, PCSR_IDX_SCR_HI);
  assign wr_duty   = reg_hit(wr_en, wr_idx, PCSR_IDX_DUTY);
  assign wr_ctrl   = reg_hit(wr_en, wr_idx, PCSR_IDX_CTRL);
  // scratch writes only in normal mode
  assign scr_wr_ok = (chip_mode_in == PCSR_MODE_NORMAL);

  // read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wr_idx)
      PCSR_IDX_RATE:   rd_data[1:0] = rate_reg;
      PCSR_IDX_PROT:   rd_data[2:0] = prot_reg;
      PCSR_IDX_SCR_LO: rd_data[7:0] = scr_lo_reg;
      PCSR_IDX_SCR_HI: rd_data[7:0] = scr_hi_reg;
      PCSR_IDX_DUTY:   rd_data[7:0] = duty_reg;
      PCSR_IDX_CTRL:   rd_data[PCSR_CTRL_LOCK] = lock_reg;
      PCSR_IDX_STAT:   rd_data[9:0] = {act_rate_reg, act_duty_reg};
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= rd_ok ? rd_data : 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------------------
  // chip select synchroniser and rising edge
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= chip_select_n_in;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  // rising edge of the synchronised select
  assign cs_rise = cs_sync_reg && !cs_prev_reg;

  // -------------------------------------------------------------------------
  // configuration lock
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_pend_reg <= 1'b0;
      lock_reg      <= 1'b0;
    end else begin
      if (wr_ctrl && !lock_reg) begin
        lock_pend_reg <= pwdata_in[PCSR_CTRL_LOCK];
      end
      if (lock_pend_reg && cs_rise) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // pwm rate and duty request registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rate_reg <= PCSR_RATE_RST[1:0];
      duty_reg <= PCSR_DUTY_RST;
    end else if (soft_rst) begin
      rate_reg <= PCSR_RATE_RST[1:0];
      duty_reg <= PCSR_DUTY_RST;
    end else begin
      if (wr_rate) begin
        rate_reg <= pwdata_in[PCSR_RATE_LSB +: 2];
      end
      if (wr_duty) begin
        duty_reg <= pwdata_in[7:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // protection tuning register
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prot_reg <= PCSR_PROT_RST[2:0];
    end else if (soft_rst && !lock_reg) begin
      prot_reg <= PCSR_PROT_RST[2:0];
    end else if (wr_prot && !lock_reg) begin
      prot_reg <= pwdata_in[2:0];
    end
  end

  assign prot_setting_out.thermal_trip_level = prot_reg[PCSR_THERM_BIT];
  assign prot_setting_out.regulator_current_limit_trim =
    prot_reg[PCSR_ILIM_LSB +: 2];

  // -------------------------------------------------------------------------
  // host scratch bytes
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scr_lo_reg <= PCSR_SCR_RST;
      scr_hi_reg <= PCSR_SCR_RST;
    end else if (scr_wr_ok) begin
      if (wr_scr_lo) begin
        scr_lo_reg <= pwdata_in[7:0];
      end
      if (wr_scr_hi) begin
        scr_hi_reg <= pwdata_in[7:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // pwm engine: step enable from divider, 255 steps per period
  // -------------------------------------------------------------------------
  assign div_limit  = rate_div(act_rate_reg);
  assign step_en    = (div_cnt_reg == div_limit - 16'h0001);
  assign period_end = step_en && (step_reg == 8'(PCSR_STEPS - 1));

  // step divider
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_reg <= 16'h0000;
    end else if (step_en) begin
      div_cnt_reg <= 16'h0000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // step counter within the period
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      step_reg <= 8'h00;
    end else if (period_end) begin
      step_reg <= 8'h00;
    end else if (step_en) begin
      step_reg <= step_reg + 8'h01;
    end
  end

  // active settings taken over at the period boundary
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_rate_reg <= PCSR_RATE_RST[1:0];
      act_duty_reg <= PCSR_DUTY_RST;
    end else if (period_end) begin
      act_rate_reg <= rate_reg;
      act_duty_reg <= duty_reg;
    end
  end

  // on while step below duty; ff stays on
  assign sw_on_next = (act_duty_reg == PCSR_DUTY_FULL) ||
                      (step_reg < act_duty_reg);

  // switch output and period marker
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_switch_on_out    <= 1'b0;
      pwm_period_start_out <= 1'b0;
    end else begin
      pwm_switch_on_out    <= sw_on_next;
      pwm_period_start_out <= period_end;
    end
  end

endmodule
`default_nettype wire

// File: tb/pcsr_host.sv
// apb host model that drives the register port of the block
`timescale 1ns/1ps
`default_nettype none
module pcsr_host (
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out,
  output logic      [3:0]  pstrb_out
);
  // idle bus at time zero
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'h000;
    pwdata_out  = 32'h0000_0000;
    pstrb_out   = 4'hf;
  end
  // one transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk_in);
    psel_out    <= 1'b1;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out  <= ~d; // released bus shows no stale data
  endtask
endmodule
`default_nettype wire

// File: tb/pcsr_top_assertions.sv
// port checker for the pwm, protection and scratch register block
`timescale 1ns/1ps
`default_nettype none
module pcsr_top_assertions
  import pcsr_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] prdata_out,
  input  wire logic        pready_out,
  input  wire logic        pslverr_out,
  input  wire pcsr_prot_t  prot_setting_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic acc;
  logic mapped;
  assign acc = psel_in && penable_in;
  assign mapped = paddr_in inside {12'h070, 12'h074, 12'h078, 12'h07c,
                                   12'h080, 12'h084, 12'h088};
  ready_high_a: assert property (acc |-> pready_out)
    else $error("pready low in access");
  unmap_err_a: assert property (acc && !mapped |-> pslverr_out)
    else $error("unmapped access without error");
  map_ok_a: assert property (acc && mapped |-> !pslverr_out)
    else $error("mapped access flagged");
  err_idle_a: assert property (!penable_in |-> !pslverr_out)
    else $error("error outside access");
  rate_upper_a: assert property (
    acc && !pwrite_in && paddr_in == 12'h070 |-> prdata_out[31:2] == 0)
    else $error("rate upper bits not zero");
  prot_read_a: assert property (
    acc && !pwrite_in && paddr_in == 12'h074
    |-> prdata_out == {29'h0000_0000, prot_setting_out})
    else $error("protection read differs from setting");
  scr_upper_a: assert property (
    acc && !pwrite_in && paddr_in inside {12'h078, 12'h07c}
    |-> prdata_out[31:8] == 0) else $error("scratch upper bits set");
  prot_hold_a: assert property ($changed(prot_setting_out) |->
    $past(acc && pwrite_in && paddr_in inside {12'h074, 12'h084}))
    else $error("protection changed without a write");
  prot_rst_a: assert property (
    $rose(reset_n_in) |-> prot_setting_out == 3'h1)
    else $error("protection reset value wrong");
  prot_wr_c: cover property (acc && pwrite_in && paddr_in == 12'h074);
  unmap_c: cover property (acc && pslverr_out);
  ctrl_wr_c: cover property (acc && pwrite_in && paddr_in == 12'h084);
endmodule
bind pcsr_top pcsr_top_assertions i_chk (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .prot_setting_out(prot_setting_out));
`default_nettype wire

// File: tb/pwm_hw_config_scratch_regs_tb.sv
// self-checking bench for the register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module pwm_hw_config_scratch_regs_tb;
  import pcsr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n = 1'b1;
  pcsr_mode_t  mode = PCSR_MODE_NORMAL;
  logic        psel, penable, pwrite, pready, pslverr, sw_on, per_st;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        e;
  pcsr_prot_t  prot;
  int          err_total = 0;
  int          tests_run = 0;
  always #2.5 clk = ~clk;
  pcsr_host i_host (.clk_in(clk), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .pstrb_out(pstrb));
  pcsr_top i_dut (.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .chip_select_n_in(cs_n),
    .chip_mode_in(mode), .pwm_switch_on_out(sw_on),
    .pwm_period_start_out(per_st), .prot_setting_out(prot));
  // register write and read-compare
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    i_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    `CHK(q, x)
  endtask
  task automatic final_report();
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rc(12'h070 + 12'(4 * i), (i == 1));
    wr(12'h070, 32'hffff_ffff);
    rc(12'h070, 32'h0000_0003);
    for (int r = 0; r < 4; r++) begin
      wr(12'h070, 32'(r));
      rc(12'h070, 32'(r));
    end
    // duty set before any pin use; nothing latches mid-period
    wr(12'h080, 32'h0000_0080);
    rc(12'h088, 32'h0000_0000);
    `CHK(sw_on, 1'b0)
    wr(12'h078, 32'h0000_00a5);
    wr(12'h07c, 32'h0000_005a);
    rc(12'h078, 32'h0000_00a5);
    rc(12'h07c, 32'h0000_005a);
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      mode <= pcsr_mode_t'(m);
      wr(12'h078, 32'(m));
      rc(12'h078, 32'h0000_00a5);
    end
    @(posedge clk);
    mode <= PCSR_MODE_NORMAL;
    for (int v = 0; v < 8; v++) begin
      wr(12'h074, 32'(v));
      @(posedge clk);
      `CHK(prot, 3'(v))
    end
    wr(12'h084, 32'h0000_0002);
    rc(12'h074, 32'h0000_0001);
    rc(12'h078, 32'h0000_00a5);
    rc(12'h070, 32'h0000_0000);
    cs_n <= 1'b0;
    wr(12'h084, 32'h0000_0001);
    wr(12'h074, 32'h0000_0006);
    rc(12'h074, 32'h0000_0006);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(12'h074, 32'h0000_0000);
    rc(12'h074, 32'h0000_0006);
    wr(12'h084, 32'h0000_0002);
    rc(12'h074, 32'h0000_0006);
    rc(12'h084, 32'h0000_0001);
    // power cycle: lock, protection and scratch back to power-on values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rc(12'h084, 32'h0000_0000);
    rc(12'h074, 32'h0000_0001);
    rc(12'h078, 32'h0000_0000);
    rc(12'h07c, 32'h0000_0000);
    wr(12'h074, 32'h0000_0005);
    rc(12'h074, 32'h0000_0005);
    // no period completes within the run: no boundary marker yet
    `CHK(per_st, 1'b0)
    i_host.xfer(1'b0, 12'h100, 32'h0000_0000, q, e);
    `CHK(e, 1'b1)
    `CHK(q, 32'h0000_0000)
    final_report();
  end
endmodule
`default_nettype wire
